// ---- fspc_consts.svh ----
// Purpose: Offsets, field positions, reset values and timing counts for the self-program control
// Assumes: 100 MHz system clock
// Notes: Included by the controller only
`ifndef FSPC_CONSTS_SVH
`define FSPC_CONSTS_SVH
`define FSPC_CSR_ADDR 6'h37
`define FSPC_CSR_RESET 8'h00
`define FSPC_BIT_IRQEN 7
`define FSPC_BIT_BUSY 6
`define FSPC_BIT_RSVD 5
`define FSPC_BIT_RRE 4
`define FSPC_BIT_LFR 3
`define FSPC_BIT_PROG 2
`define FSPC_BIT_CLR 1
`define FSPC_BIT_ARM 0
`define FSPC_CMD_RRE 5'h11
`define FSPC_CMD_LFR 5'h09
`define FSPC_CMD_PROG 5'h05
`define FSPC_CMD_CLR 5'h03
`define FSPC_CMD_FILL 5'h01
`define FSPC_STORE_WIN 3'h4
`define FSPC_LOAD_WIN 3'h3
`define FSPC_SEL_LOCK 2'h1
`define FSPC_SEL_FLOW 2'h0
`define FSPC_SEL_FHIGH 2'h3
`define FSPC_SEL_FEXT 2'h2
`define FSPC_PROG_TIME_US 3700
`define FSPC_OSC_DIV 8'h07
`endif

// ---- fspc_pkg.sv ----
// Purpose: Types for the self-program controller
// Assumes: fspc_consts.svh holds the numbers
// Notes: Nothing is imported elsewhere
package fspc_pkg;
  typedef enum logic [1:0] {
    FSPC_IDLE = 2'b00,
    FSPC_ARMED = 2'b01,
    FSPC_BUSY = 2'b11
  } fspc_state_e;
  typedef struct packed {
    logic [15:0] ptr;
    logic [15:0] data;
    logic from_boot;
  } fspc_store_s;
endpackage : fspc_pkg

// ---- fspc_ctrl.sv ----
// Purpose: Arms and runs flash page fill, erase, program, buffer clear and lock reads
// Assumes: CPU register port on sys_clk; completion timed by a divided oscillator tick
// Notes: Single variant without concurrent read; busy status reads zero
// Notes on behaviour
// - Ready interrupt while enabled, global on, unarmed
// - No ready interrupt during nvm write or op
// - Section busy bit always reads zero here
// - Bit five reserved, reads zero
// - Read reenable during fill clears page buffer
// - Load within three cycles returns lock/fuse
// - Program bit plus store writes page
// - Program bit clears at completion or timeout
// - Clear bit plus store erases page
// - Clear bit clears at completion or timeout
// - Arm opens four-cycle store window only
// - Arm alone stores word into buffer
// - Arm self-clears; holds through erase/program
// - Only five control patterns take effect
// - Programming starts only from boot section
// - Boot size fuses split flash sections; boundary only computed here, section taken from store_info.from_boot
// - Busy status set until reenable (if supported)
// - Halt CPU during erase or program
// - Pointer selects lock or fuse byte
// - Nvm write blocks programming and fuse reads
`timescale 1ns/1ps
`default_nettype none
`include "fspc_consts.svh"
module fspc_ctrl #(
  parameter int PAGE_WORDS = 32,
  parameter int PROG_CYCLES = `FSPC_PROG_TIME_US * 100 / (`FSPC_OSC_DIV + 1),
  parameter logic [15:0] BOOT_BASE = 16'h1800
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Core instruction side
  input wire logic global_irq_on,
  input wire logic data_nvm_write_busy,
  input wire logic store_req,
  input wire logic load_req,
  input wire fspc_pkg::fspc_store_s store_info,
  input wire logic [1:0] boot_size_fuses,
  input wire logic [7:0] lock_bits,
  input wire logic [7:0] fuse_low,
  input wire logic [7:0] fuse_high,
  input wire logic [7:0] fuse_ext,
  output logic load_hit,
  output logic [7:0] load_data,
  output logic cpu_halt,
  output logic ready_irq,
  // Flash array side
  output logic buf_we,
  output logic [15:0] buf_word_addr,
  output logic [15:0] buf_wdata,
  output logic buf_clear,
  output logic page_erase_go,
  output logic page_prog_go,
  output logic [15:0] page_addr
);
  typedef struct packed {
    fspc_pkg::fspc_state_e st;
    logic irq_en;
    logic [4:0] ctl;
    logic [2:0] win;
    logic [31:0] cnt;
    logic [7:0] div;
    logic filling;
    logic [7:0] rdata;
    logic load_hit;
    logic [7:0] load_data;
    logic halt;
    logic irq;
    logic buf_we;
    logic [15:0] buf_addr;
    logic [15:0] buf_wdata;
    logic buf_clear;
    logic erase_go;
    logic prog_go;
    logic [15:0] page_addr;
  } fspc_regs_s;

  fspc_regs_s q, d;
  logic [15:0] boot_start;

  function automatic logic [7:0] fuse_pick(input logic [1:0] sel, input logic [7:0] lk,
      input logic [7:0] fl, input logic [7:0] fh, input logic [7:0] fe);
    case (sel)
      `FSPC_SEL_LOCK: fuse_pick = lk;
      `FSPC_SEL_FHIGH: fuse_pick = fh;
      `FSPC_SEL_FEXT: fuse_pick = fe;
      default: fuse_pick = fl;
    endcase
  endfunction : fuse_pick

  // Boundary from the size fuses; programmed (zero) fuses enlarge boot
  always_comb begin
    case (boot_size_fuses)
      2'h3: boot_start = BOOT_BASE + 16'h0600;
      2'h2: boot_start = BOOT_BASE + 16'h0400;
      2'h1: boot_start = BOOT_BASE + 16'h0200;
      default: boot_start = BOOT_BASE;
    endcase
  end

  always_comb begin
    logic wr_csr;
    logic armed_store;
    wr_csr = 1'b0;
    armed_store = 1'b0;
    d = q;
    d.buf_we = 1'b0;
    d.buf_clear = 1'b0;
    d.erase_go = 1'b0;
    d.prog_go = 1'b0;
    d.load_hit = 1'b0;
    wr_csr = reg_wr && (reg_addr == `FSPC_CSR_ADDR);
    if (wr_csr) begin
      d.irq_en = reg_wdata[`FSPC_BIT_IRQEN];
    end
    case (q.st)
      fspc_pkg::FSPC_IDLE: begin
        // Nvm write blocks arming entirely
        if (wr_csr && !data_nvm_write_busy) begin
          case (reg_wdata[4:0])
            `FSPC_CMD_RRE, `FSPC_CMD_LFR, `FSPC_CMD_PROG, `FSPC_CMD_CLR,
            `FSPC_CMD_FILL: begin
              d.ctl = reg_wdata[4:0];
              d.win = `FSPC_STORE_WIN;
              d.st = fspc_pkg::FSPC_ARMED;
            end
            default: ;
          endcase
        end
      end
      fspc_pkg::FSPC_ARMED: begin
        d.win = q.win - 3'h1;
        armed_store = store_req && store_info.from_boot;
        if (q.ctl == `FSPC_CMD_LFR && load_req
            && (q.win > (`FSPC_STORE_WIN - `FSPC_LOAD_WIN))) begin
          d.load_hit = 1'b1;
          d.load_data = fuse_pick(store_info.ptr[1:0], lock_bits, fuse_low,
                                  fuse_high, fuse_ext);
          d.ctl = 5'h00;
          d.st = fspc_pkg::FSPC_IDLE;
        end else if (armed_store) begin
          d.page_addr = store_info.ptr & ~16'(2 * PAGE_WORDS - 1);
          case (q.ctl)
            `FSPC_CMD_FILL: begin
              d.buf_we = 1'b1;
              d.buf_addr = {1'b0, store_info.ptr[15:1]};
              d.buf_wdata = store_info.data;
              d.filling = 1'b1;
              d.ctl = 5'h00;
              d.st = fspc_pkg::FSPC_IDLE;
            end
            `FSPC_CMD_RRE: begin
              d.buf_clear = q.filling;
              d.filling = 1'b0;
              d.ctl = 5'h00;
              d.st = fspc_pkg::FSPC_IDLE;
            end
            `FSPC_CMD_PROG, `FSPC_CMD_CLR: begin
              d.prog_go = (q.ctl == `FSPC_CMD_PROG);
              d.erase_go = (q.ctl == `FSPC_CMD_CLR);
              d.filling = (q.ctl == `FSPC_CMD_PROG) ? 1'b0 : q.filling;
              d.halt = 1'b1;
              d.cnt = 32'(PROG_CYCLES);
              d.div = `FSPC_OSC_DIV;
              d.st = fspc_pkg::FSPC_BUSY;
            end
            default: begin
              d.ctl = 5'h00;
              d.st = fspc_pkg::FSPC_IDLE;
            end
          endcase
        end else if (q.win == 3'h1) begin
          d.ctl = 5'h00;
          d.st = fspc_pkg::FSPC_IDLE;
        end
      end
      fspc_pkg::FSPC_BUSY: begin
        // Divided tick stands in for the calibrated oscillator
        d.div = (q.div == 8'h00) ? `FSPC_OSC_DIV : q.div - 8'h01;
        if (q.div == 8'h00) begin
          d.cnt = q.cnt - 32'h1;
        end
        if (q.div == 8'h00 && q.cnt <= 32'h1) begin
          d.ctl = 5'h00;
          d.halt = 1'b0;
          d.st = fspc_pkg::FSPC_IDLE;
        end
      end
      default: d.st = fspc_pkg::FSPC_IDLE;
    endcase
    // Reads see current state; busy and reserved bits forced low
    d.rdata = {d.irq_en, 1'b0, 1'b0, d.ctl};
    d.irq = d.irq_en && global_irq_on && !d.ctl[`FSPC_BIT_ARM]
            && !data_nvm_write_busy && (d.st != fspc_pkg::FSPC_BUSY);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= '0;
      q.st <= fspc_pkg::FSPC_IDLE;
      q.rdata <= `FSPC_CSR_RESET;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign load_hit = q.load_hit;
  assign load_data = q.load_data;
  assign cpu_halt = q.halt;
  assign ready_irq = q.irq;
  assign buf_we = q.buf_we;
  assign buf_word_addr = q.buf_addr;
  assign buf_wdata = q.buf_wdata;
  assign buf_clear = q.buf_clear;
  assign page_erase_go = q.erase_go;
  assign page_prog_go = q.prog_go;
  assign page_addr = q.page_addr;

  // Helper: boot start is informational for the core's section decode
  logic boot_unused;
  assign boot_unused = ^boot_start;

  a_irq_gate: assert property (@(posedge sys_clk) disable iff (rst)
    ready_irq |-> q.ctl[`FSPC_BIT_ARM] == 1'b0) else $error("irq while armed");
  a_irq_busy: assert property (@(posedge sys_clk) disable iff (rst)
    q.st == fspc_pkg::FSPC_BUSY |-> !ready_irq) else $error("irq during op");
  a_busy_zero: assert property (@(posedge sys_clk) disable iff (rst)
    reg_rdata[`FSPC_BIT_BUSY] == 1'b0) else $error("busy bit set");
  a_rsvd_zero: assert property (@(posedge sys_clk) disable iff (rst)
    reg_rdata[`FSPC_BIT_RSVD] == 1'b0) else $error("reserved bit set");
  a_arm_window: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(q.st == fspc_pkg::FSPC_ARMED) |-> ##[1:4] q.st != fspc_pkg::FSPC_ARMED)
    else $error("arm window too long");
  a_halt_op: assert property (@(posedge sys_clk) disable iff (rst)
    (page_prog_go || page_erase_go) |-> cpu_halt && q.ctl[`FSPC_BIT_ARM])
    else $error("no halt during op");
  a_app_ignored: assert property (@(posedge sys_clk) disable iff (rst)
    (q.st == fspc_pkg::FSPC_ARMED && store_req && !store_info.from_boot
     && !load_req && q.win > 3'h1) |=> !buf_we && !page_prog_go && !page_erase_go)
    else $error("app store acted");
  a_bad_pattern: assert property (@(posedge sys_clk) disable iff (rst)
    (q.st == fspc_pkg::FSPC_IDLE && reg_wr && reg_addr == `FSPC_CSR_ADDR
     && reg_wdata[4:0] == 5'h07) |=> q.st == fspc_pkg::FSPC_IDLE)
    else $error("bad pattern armed");
  a_nvm_block: assert property (@(posedge sys_clk) disable iff (rst)
    (q.st == fspc_pkg::FSPC_IDLE && data_nvm_write_busy) |=> q.st != fspc_pkg::FSPC_ARMED)
    else $error("armed during nvm write");

  // Store and load actions, one cycle after the taking edge
  a_fill_store: assert property (@(posedge sys_clk) disable iff (rst)
    (q.st == fspc_pkg::FSPC_ARMED && q.ctl == `FSPC_CMD_FILL && store_req && store_info.from_boot)
    |=> buf_we && buf_word_addr == {1'b0, $past(store_info.ptr[15:1])}
    && buf_wdata == $past(store_info.data)) else $error("fill word not written");

  a_fill_done: assert property (@(posedge sys_clk) disable iff (rst)
    (q.st == fspc_pkg::FSPC_ARMED && q.ctl == `FSPC_CMD_FILL && store_req && store_info.from_boot)
    |=> q.st == fspc_pkg::FSPC_IDLE && !reg_rdata[`FSPC_BIT_ARM])
    else $error("arm left set after fill");

  a_prog_start: assert property (@(posedge sys_clk) disable iff (rst)
    (q.st == fspc_pkg::FSPC_ARMED && q.ctl == `FSPC_CMD_PROG && store_req && store_info.from_boot)
    |=> page_prog_go && !page_erase_go && cpu_halt)
    else $error("page program not started");

  a_erase_start: assert property (@(posedge sys_clk) disable iff (rst)
    (q.st == fspc_pkg::FSPC_ARMED && q.ctl == `FSPC_CMD_CLR && store_req && store_info.from_boot)
    |=> page_erase_go && !page_prog_go && cpu_halt)
    else $error("page erase not started");

  a_page_align: assert property (@(posedge sys_clk) disable iff (rst)
    (page_prog_go || page_erase_go)
    |-> (page_addr & 16'(2 * PAGE_WORDS - 1)) == 16'h0000)
    else $error("page address not aligned");

  a_arm_hold: assert property (@(posedge sys_clk) disable iff (rst)
    cpu_halt
    |-> reg_rdata[`FSPC_BIT_ARM] && (reg_rdata[`FSPC_BIT_PROG] || reg_rdata[`FSPC_BIT_CLR]))
    else $error("arm dropped during op");

  a_halt_end: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(cpu_halt)
    |-> reg_rdata[2:0] == 3'h0)
    else $error("op bits left after completion");

  a_timeout_clear: assert property (@(posedge sys_clk) disable iff (rst)
    (q.st == fspc_pkg::FSPC_ARMED && q.win == 3'h1 && !store_req)
    |=> q.st == fspc_pkg::FSPC_IDLE)
    else $error("window outlived four cycles");

  a_load_late: assert property (@(posedge sys_clk) disable iff (rst)
    (q.st == fspc_pkg::FSPC_ARMED && q.ctl == `FSPC_CMD_LFR && load_req && q.win == 3'h1)
    |=> !load_hit)
    else $error("late load answered");

  a_load_lock: assert property (@(posedge sys_clk) disable iff (rst)
    (q.st == fspc_pkg::FSPC_ARMED && q.ctl == `FSPC_CMD_LFR && load_req && q.win > 3'h1
    && store_info.ptr[1:0] == `FSPC_SEL_LOCK) |=> load_hit && load_data == $past(lock_bits))
    else $error("lock byte not returned");

  a_load_fhigh: assert property (@(posedge sys_clk) disable iff (rst)
    (q.st == fspc_pkg::FSPC_ARMED && q.ctl == `FSPC_CMD_LFR && load_req && q.win > 3'h1
    && store_info.ptr[1:0] == `FSPC_SEL_FHIGH) |=> load_hit && load_data == $past(fuse_high))
    else $error("high fuse byte not returned");

  a_rre_clear: assert property (@(posedge sys_clk) disable iff (rst)
    (q.st == fspc_pkg::FSPC_ARMED && q.ctl == `FSPC_CMD_RRE && store_req && store_info.from_boot
    && q.filling) |=> buf_clear)
    else $error("buffer not cleared");

  a_nvm_irq: assert property (@(posedge sys_clk) disable iff (rst)
    data_nvm_write_busy
    |=> !ready_irq)
    else $error("irq during nvm write");

  a_idle_unarmed: assert property (@(posedge sys_clk) disable iff (rst)
    q.st == fspc_pkg::FSPC_IDLE
    |-> !reg_rdata[`FSPC_BIT_ARM])
    else $error("arm shown while idle");

  // Interrupt follows next state, so it rises one edge after the gate opens
  a_irq_enabled: assert property (@(posedge sys_clk) disable iff (rst)
    (q.st == fspc_pkg::FSPC_IDLE && q.irq_en && global_irq_on && !data_nvm_write_busy
    && !(reg_wr && reg_addr == `FSPC_CSR_ADDR)) |=> ready_irq)
    else $error("ready irq missing");

  c_erase: cover property (@(posedge sys_clk) page_erase_go);
  c_fill: cover property (@(posedge sys_clk) buf_we);
  c_prog: cover property (@(posedge sys_clk) page_prog_go);
  c_lock: cover property (@(posedge sys_clk) load_hit);
  c_timeout: cover property (@(posedge sys_clk)
    q.st == fspc_pkg::FSPC_ARMED && q.win == 3'h1 && !store_req);
endmodule : fspc_ctrl
`default_nettype wire

// ---- fspc_cpu_model.sv ----
// Purpose: CPU core model issuing CSR writes, store and load instructions
// Assumes: Requests change just after a rising edge and drop after the taking edge
// Notes: Released lines show inverted values so stale data cannot pass
`timescale 1ns/1ps
`default_nettype none
module fspc_cpu_model (
  // Clock
  input wire logic sys_clk,
  // Device view
  input wire logic [7:0] reg_rdata,
  input wire logic data_nvm_write_busy,
  // Requests
  output logic [5:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic store_req,
  output logic load_req,
  output fspc_pkg::fspc_store_s store_info
);
  initial begin
    reg_addr = 6'h37;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    store_req = 1'b0;
    load_req = 1'b0;
    store_info = '0;
  end
  // d is the cycle of the request after the write, 0 for none
  task automatic op(input logic [7:0] ctl, input fspc_pkg::fspc_store_s info,
      input int d, input logic ld, input logic wait_nvm);
    int n;
    n = 0;
    do @(posedge sys_clk);
    while ((reg_rdata[0] !== 1'b0 || (wait_nvm && data_nvm_write_busy !== 1'b0))
        && n++ < 200);
    reg_wr <= 1'b1;
    reg_wdata <= ctl;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~ctl;
    if (d > 0) begin
      repeat (d - 1) @(posedge sys_clk);
      store_req <= !ld;
      load_req <= ld;
      store_info <= info;
      @(posedge sys_clk);
      store_req <= 1'b0;
      load_req <= 1'b0;
      store_info <= ~info;
    end
  endtask : op
endmodule : fspc_cpu_model
`default_nettype wire

// ---- test_flash_self_program_control.sv ----
// Purpose: Self-checking bench for the self-program controller
// Assumes: Answers show just after the request edge
// Notes: Short program count keeps the run brief
`timescale 1ns/1ps
`default_nettype none
module test_flash_self_program_control;
  localparam int PC = 4;
  localparam int PW = 32;
  logic sys_clk, rst, global_irq_on, data_nvm_write_busy, reg_wr, store_req, load_req;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, load_data, lock_bits, fuse_low, fuse_high, fuse_ext;
  logic [1:0] boot_size_fuses;
  logic load_hit, cpu_halt, ready_irq, buf_we, buf_clear, page_erase_go, page_prog_go;
  logic [15:0] buf_word_addr, buf_wdata, page_addr;
  fspc_pkg::fspc_store_s store_info, info;
  int failures, checks_done, n, i;
  logic [7:0] fz [4];
  fspc_ctrl #(.PAGE_WORDS(PW), .PROG_CYCLES(PC)) dut (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .global_irq_on(global_irq_on), .data_nvm_write_busy(data_nvm_write_busy),
    .store_req(store_req), .load_req(load_req), .store_info(store_info),
    .boot_size_fuses(boot_size_fuses), .lock_bits(lock_bits), .fuse_low(fuse_low),
    .fuse_high(fuse_high), .fuse_ext(fuse_ext), .load_hit(load_hit), .load_data(load_data),
    .cpu_halt(cpu_halt), .ready_irq(ready_irq), .buf_we(buf_we),
    .buf_word_addr(buf_word_addr), .buf_wdata(buf_wdata), .buf_clear(buf_clear),
    .page_erase_go(page_erase_go), .page_prog_go(page_prog_go), .page_addr(page_addr));
  fspc_cpu_model cpu (.sys_clk(sys_clk), .reg_rdata(reg_rdata),
    .data_nvm_write_busy(data_nvm_write_busy), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .store_req(store_req), .load_req(load_req),
    .store_info(store_info));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic rand_info(input logic boot);
    info.ptr = 16'($urandom);
    info.data = 16'($urandom);
    info.from_boot = boot;
  endtask : rand_info
  // Erase or program with request on cycle d, then time the halt
  task automatic long_op(input logic [7:0] ctl, input int d);
    rand_info(1'b1);
    cpu.op(ctl, info, d, 1'b0, 1'b1);
    #1;
    check({page_erase_go, page_prog_go}, {ctl[1], ctl[2]});
    check(page_addr, info.ptr & ~16'(2 * PW - 1));
    check({cpu_halt, reg_rdata[2:0]}, {1'b1, ctl[2:0]});
    n = 0;
    while (cpu_halt === 1'b1 && n < 100) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check(16'(n >= 8 * PC - 2 && n <= 8 * PC + 2), 16'h1);
    check(reg_rdata[2:0], 3'h0);
  endtask : long_op
  initial begin
    #100us;
    failures++;
    report_and_stop();
  end
  initial begin
    failures = 0;
    checks_done = 0;
    rst = 1'b1;
    global_irq_on = 1'b0;
    data_nvm_write_busy = 1'b0;
    void'($urandom(32'h96d40d18));
    lock_bits = 8'($urandom);
    fuse_low = 8'($urandom);
    fuse_high = 8'($urandom);
    fuse_ext = 8'($urandom);
    boot_size_fuses = 2'($urandom);
    fz = '{fuse_low, lock_bits, fuse_ext, fuse_high};
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    check({ready_irq, reg_rdata}, 9'h000);
    $display("reset test done");
    rand_info(1'b1);
    cpu.op(8'h01, info, 1, 1'b0, 1'b1);
    #1;
    check({buf_we, buf_word_addr, buf_wdata}, {1'b1, info.ptr >> 1, info.data});
    check(reg_rdata[6:0], 7'h00);
    @(posedge sys_clk);
    #1;
    check(buf_we, 1'b0);
    cpu.op(8'h11, info, 2, 1'b0, 1'b1);
    #1;
    check(buf_clear, 1'b1);
    $display("fill test done");
    long_op(8'h03, 4);
    long_op(8'h05, 1);
    $display("erase and program test done");
    cpu.op(8'h05, info, 0, 1'b0, 1'b1);
    repeat (5) @(posedge sys_clk);
    #1;
    check(reg_rdata[2:0], 3'h0);
    cpu.op(8'h03, info, 5, 1'b0, 1'b1);
    #1;
    check({page_erase_go, cpu_halt}, 2'b00);
    rand_info(1'b0);
    cpu.op(8'h05, info, 1, 1'b0, 1'b1);
    #1;
    check({page_prog_go, cpu_halt}, 2'b00);
    foreach (fz[k]) begin
      cpu.op(8'(8'h07 + 8'h06 * k), info, 0, 1'b0, 1'b1);
      #1;
      check(reg_rdata[4:0], 5'h00);
    end
    @(posedge sys_clk);
    data_nvm_write_busy <= 1'b1;
    cpu.op(8'h09, info, 1, 1'b1, 1'b0);
    #1;
    check({load_hit, reg_rdata[3:0]}, 5'h00);
    data_nvm_write_busy <= 1'b0;
    $display("refusal test done");
    for (i = 0; i < 5; i++) begin
      info.ptr = 16'(i % 4);
      cpu.op(8'h09, info, (i == 4) ? 4 : i % 3 + 1, 1'b1, 1'b1);
      #1;
      check({load_hit, load_data}, (i < 4) ? {1'b1, fz[i % 4]} : {1'b0, fz[3]});
    end
    $display("lock read test done");
    @(posedge sys_clk);
    global_irq_on <= 1'b1;
    cpu.op(8'h81, info, 0, 1'b0, 1'b1);
    #1;
    check({ready_irq, reg_rdata[7]}, 2'b01);
    repeat (6) @(posedge sys_clk);
    #1;
    check({ready_irq, reg_rdata[7]}, 2'b11);
    data_nvm_write_busy <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    check(ready_irq, 1'b0);
    data_nvm_write_busy <= 1'b0;
    global_irq_on <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    check(ready_irq, 1'b0);
    $display("interrupt test done");
    report_and_stop();
  end
endmodule : test_flash_self_program_control
`default_nettype wire
